// file: design/sls_driver.sv
// Serial-in latched sink driver: shift stage, load FIFO, storage register,
// blanking output buffers and cascade output.
// Assumes all control pins are synchronous to clk and held at least one cycle.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Generic flip-flop FIFO, power-of-two depth
// Limitation: pointers wrap by overflow, so DEPTH must be a power of two
module sls_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  // Level flags
  output logic                  full,
  output logic                  empty
);
  localparam int          AW        = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  // Honest flags straight from the occupancy count
  assign full      = (count_r == DEPTH_CNT);
  assign empty     = (count_r == '0);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem_r[rd_ptr_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage array has no reset; never read before written
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // Pointers wrap naturally since depth is a power of two
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end

  // Occupancy
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_r <= '0;
    end else if (push && !pop) begin
      count_r <= count_r + 1'b1;
    end else if (pop && !push) begin
      count_r <= count_r - 1'b1;
    end
  end

  // Occupancy never passes the depth; an overrun would overwrite queued words
  a_fifo_bound: assert property (@(posedge clk) disable iff (!reset_n)
    count_r <= DEPTH_CNT)
    else $error("fifo count beyond depth");

endmodule

////////////////////////////////////////////////////////////////////////////////
// Top level driver
module sls_driver #(
  parameter int WIDTH      = sls_pkg::SLS_WIDTH,
  parameter int FIFO_DEPTH = sls_pkg::SLS_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Serial interface
  input  wire logic             shift_data_in,
  input  wire sls_pkg::sls_ctrl_t ctrl,
  output logic                  cascade_out,
  // Load buffering
  input  wire logic             storage_hold,
  output logic                  load_ready,
  // Sink outputs, high means sinking
  output logic [WIDTH-1:0]      sink_on
);
  import sls_pkg::*;

  logic [WIDTH-1:0] shift_r;
  logic [WIDTH-1:0] storage_r;
  logic             cascade_r;
  logic             shift_clk_prev_r;
  logic             load_clk_prev_r;
  logic             shift_edge;
  logic             load_edge;
  logic             fifo_valid;
  logic [WIDTH-1:0] fifo_data;
  logic             fifo_full;
  logic             fifo_empty;
  logic             pop;

  // Rising edge of a sampled pin against its previous sample
  function automatic logic rise(input logic now_v, input logic prev_v);
    rise = now_v && !prev_v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin edge detection; pins are synchronous so no synchroniser
  // Previous samples reset low, the idle level, so no false edge follows reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_clk_prev_r <= SLS_PIN_RST;
      load_clk_prev_r  <= SLS_PIN_RST;
    end else begin
      shift_clk_prev_r <= ctrl.shift_clock_in;
      load_clk_prev_r  <= ctrl.storage_load_clock;
    end
  end

  assign shift_edge = rise(ctrl.shift_clock_in, shift_clk_prev_r);
  assign load_edge  = rise(ctrl.storage_load_clock, load_clk_prev_r);

  ////////////////////////////////////////////////////////////////////////////
  // Shift stage; clear outranks a coincident shift edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_r <= SLS_SHIFT_RST;
    end else if (!ctrl.shift_clear_n) begin
      shift_r <= '0; // R4
    end else if (shift_edge) begin
      shift_r <= {shift_r[WIDTH-2:0], shift_data_in}; // R1 R2
    end
  end

  // Cascade follows the last stage as it moves
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cascade_r <= SLS_PIN_RST;
    end else if (!ctrl.shift_clear_n) begin
      cascade_r <= 1'b0;
    end else if (shift_edge) begin
      cascade_r <= shift_r[WIDTH-2]; // R8 R10
    end
  end

  assign cascade_out = cascade_r;

  ////////////////////////////////////////////////////////////////////////////
  // Load words queue here so a stalled storage side loses no update until the buffer is full;
  // the cost is two cycles of latency between load edge and storage.
  sls_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (load_edge),
    .in_ready  (load_ready),
    .in_data   (shift_r), // R3
    .out_valid (fifo_valid),
    .out_ready (!storage_hold),
    .out_data  (fifo_data),
    .full      (fifo_full),
    .empty     (fifo_empty)
  );

  assign pop = fifo_valid && !storage_hold;

  // Storage register takes a whole word at once
  // Outputs change once per word, never bit by bit while shifting
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      storage_r <= SLS_STORE_RST;
    end else if (pop) begin
      storage_r <= fifo_data; // R3
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output buffers are transparent; blanking and clear gate them
  always_comb begin
    if (ctrl.output_blank) begin
      sink_on = '0; // R6
    end else if (!ctrl.shift_clear_n) begin
      sink_on = '0; // R5
    end else begin
      sink_on = storage_r; // R7 R9
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks; each label line but a_full_refuse carries the tag of the rule it guards
  // Shift stage and cascade
  a_clear_zeros: assert property (@(posedge clk) disable iff (!reset_n) // R4
    !ctrl.shift_clear_n |=> (shift_r == '0) && !cascade_out)
    else $error("shift stage not cleared");

  a_shift_advance: assert property (@(posedge clk) disable iff (!reset_n) // R2
    (shift_edge && ctrl.shift_clear_n) |=>
      shift_r == {$past(shift_r[WIDTH-2:0]), $past(shift_data_in)})
    else $error("shift did not advance");

  a_shift_idle: assert property (@(posedge clk) disable iff (!reset_n) // R1
    (!shift_edge && ctrl.shift_clear_n) |=> $stable(shift_r))
    else $error("shift moved without edge");

  // A shift clock held high must count once, or one pulse shifts many bits
  a_edge_once: assert property (@(posedge clk) disable iff (!reset_n) // R2
    shift_edge |=> !shift_edge)
    else $error("shift edge seen twice");

  // Cascade is the last stage itself, checked in every cycle
  a_cascade_tail: assert property (@(posedge clk) disable iff (!reset_n) // R10
    cascade_out == shift_r[WIDTH-1])
    else $error("cascade not last stage");

  a_cascade_still: assert property (@(posedge clk) disable iff (!reset_n) // R8
    (!shift_edge && ctrl.shift_clear_n) |=> $stable(cascade_out))
    else $error("cascade moved without edge");

  ////////////////////////////////////////////////////////////////////////////
  // Load path and storage register
  a_load_once: assert property (@(posedge clk) disable iff (!reset_n) // R3
    load_edge |=> !load_edge)
    else $error("load edge seen twice");

  a_load_push: assert property (@(posedge clk) disable iff (!reset_n) // R3
    (load_edge && load_ready) |=> !fifo_empty)
    else $error("load word not queued");

  a_load_word: assert property (@(posedge clk) disable iff (!reset_n) // R3
    (load_edge && fifo_empty && !storage_hold) ##1 !storage_hold |=>
      storage_r == $past(shift_r, 2))
    else $error("storage did not take word");

  a_hold_keeps: assert property (@(posedge clk) disable iff (!reset_n) // R3
    storage_hold |=> $stable(storage_r))
    else $error("storage changed during hold");

  a_store_only_pop: assert property (@(posedge clk) disable iff (!reset_n) // R3
    !pop |=> $stable(storage_r))
    else $error("storage changed without a word");

  a_full_refuse: assert property (@(posedge clk) disable iff (!reset_n)
    fifo_full |-> !load_ready)
    else $error("ready while fifo full");

  // Once the storage side drains a word, a full buffer takes loads again
  a_ready_after_pop: assert property (@(posedge clk) disable iff (!reset_n) // R3
    (fifo_full && pop) |=> load_ready)
    else $error("ready not back after drain");

  ////////////////////////////////////////////////////////////////////////////
  // Output buffers
  a_blank_off: assert property (@(posedge clk) disable iff (!reset_n) // R6
    ctrl.output_blank |-> (sink_on == '0))
    else $error("outputs on while blanked");

  a_follow_store: assert property (@(posedge clk) disable iff (!reset_n) // R7
    (!ctrl.output_blank && ctrl.shift_clear_n) |-> (sink_on == storage_r))
    else $error("outputs not following storage");

  a_clear_gate: assert property (@(posedge clk) disable iff (!reset_n) // R5
    !ctrl.shift_clear_n |-> (sink_on == '0))
    else $error("outputs on during clear");

  // No sink may conduct unless its stored bit is one
  a_sink_subset: assert property (@(posedge clk) disable iff (!reset_n) // R9
    (sink_on & ~storage_r) == '0)
    else $error("sink on without stored one");

  ////////////////////////////////////////////////////////////////////////////
  // Coverage of the main scenarios
  c_back_shifts: cover property (@(posedge clk) disable iff (!reset_n)
    (shift_edge && ctrl.shift_clear_n) ##2 (shift_edge && ctrl.shift_clear_n));

  c_load_seen: cover property (@(posedge clk) disable iff (!reset_n)
    load_edge ##[1:4] pop);

  c_fifo_full: cover property (@(posedge clk) disable iff (!reset_n)
    fifo_full);

  c_blank_on: cover property (@(posedge clk) disable iff (!reset_n)
    (sink_on != '0) ##1 ctrl.output_blank);

endmodule

// file: design/sls_pkg.sv
// Constants and carrier types for the latched serial sink driver.
// Assumes a single 250 MHz clock; every pin is taken synchronous to it.
//
// Overview of operation
// R1 - Eight-stage serial shift register feeds an eight-bit D-type storage register.
// R2 - Each shift clock rising edge advances one stage, serial input enters first.
// R3 - Each storage clock rising edge copies all eight stages into storage together; here two cycles later via the buffer, an edge while it is full is dropped.
// R4 - While shift clear is low, every shift stage is forced to zero.
// R5 - Storage contents reach the output buffers only while shift clear is high.
// R6 - While blanking input is high, all eight buffer values are forced low.
// R7 - While blanking input is low, buffers follow storage bits combinationally; here only while shift clear is also high.
// R8 - Shift register data appears on a serial cascade output for chaining.
// R9 - Each sink output is on when its buffer bit is one, else off.
// R10 - Cascade output shows stage eight, eight shift edges after entry.
// R11 - Controller shifts eight bits, first to last output, then pulses storage clock.
package sls_pkg;

  // Data path sizes
  localparam int SLS_WIDTH      = 8;
  localparam int SLS_FIFO_DEPTH = 32;

  // Reset values
  localparam logic [7:0] SLS_SHIFT_RST = 8'h00;
  localparam logic [7:0] SLS_STORE_RST = 8'h00;
  localparam logic       SLS_PIN_RST   = 1'h0;

  // Clock period, for reference by timing-aware users
  localparam int SLS_CLK_PERIOD_NS = 4;

  // Control pins sampled each clock
  typedef struct packed {
    logic shift_clock_in;
    logic storage_load_clock;
    logic shift_clear_n;
    logic output_blank;
  } sls_ctrl_t;

endpackage

// file: testbench/sls_host_model.sv
// Controller model that drives the shift, load, clear and blank pins.
// Assumes clk is the driver's clock; pins change 1 ns after its rising edge.
`timescale 1ns/10ps
module sls_host_model (
  // Clock
  input  wire logic          clk,
  // Pins toward the driver
  output logic               shift_data_in,
  output sls_pkg::sls_ctrl_t ctrl
);
  import sls_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Idle pins: clocks low, clear released, outputs shown
  initial begin
    shift_data_in = 1'h0;
    ctrl          = 4'h2;
  end

  // One shift edge; after the hold the data line shows the inverse, not stale data
  task automatic shift_bit(input logic d);
    @(posedge clk) #1;
    shift_data_in       = d;
    ctrl.shift_clock_in = 1'h1;
    @(posedge clk) #1;
    ctrl.shift_clock_in = 1'h0;
    shift_data_in       = ~d;
  endtask

  // Storage pulse, high for one clock, whatever the shift stage holds
  task automatic pulse_load;
    @(posedge clk) #1;
    ctrl.storage_load_clock = 1'h1;
    @(posedge clk) #1;
    ctrl.storage_load_clock = 1'h0;
  endtask

  // Clear and blanking levels
  task automatic set_pins(input logic clr_n, input logic blank);
    @(posedge clk) #1;
    ctrl.shift_clear_n = clr_n;
    ctrl.output_blank  = blank;
  endtask
endmodule

// file: testbench/testbench.sv
// Self-checking bench for the latched sink driver.
// Assumes the host model drives shift_data_in and ctrl; clk, reset_n and storage_hold are driven from here.
`timescale 1ns/10ps
module testbench;
  import sls_pkg::*;
  logic       clk, reset_n, shift_data_in, cascade_out, storage_hold, load_ready;
  sls_ctrl_t  ctrl;
  logic [7:0] sink_on, sr, last;
  int         num_errors, check_count, seed, i;
  int         cycles = 0;

  sls_driver dut (.clk(clk), .reset_n(reset_n), .shift_data_in(shift_data_in), .ctrl(ctrl),
    .cascade_out(cascade_out), .storage_hold(storage_hold), .load_ready(load_ready),
    .sink_on(sink_on));
  sls_host_model host (.clk(clk), .shift_data_in(shift_data_in), .ctrl(ctrl));

  ////////////////////////////////////////////////////////////////////////////
  // 250 MHz clock and hang guard; the run needs under 2000 cycles
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      stop_test();
    end
  end

  // Expected shift stage after one edge
  function automatic logic [7:0] shift_next(input logic [7:0] s, input logic d);
    return {s[6:0], d};
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Eight edges, first bit sent ends at the last output
  task automatic send_byte(input logic [7:0] b);
    for (int k = 7; k >= 0; k--) begin
      host.shift_bit(b[k]);
      sr = shift_next(sr, b[k]);
      check({7'h00, cascade_out}, {7'h00, sr[7]});
    end
  endtask

  // Load pulse, then room for the two-cycle buffer latency
  task automatic load_word;
    host.pulse_load();
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic stop_test;
    if (num_errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 20;
    num_errors = 0;
    check_count = 0;
    sr = 8'h00;
    reset_n = 1'h0;
    storage_hold = 1'h0;
    repeat (20) @(posedge clk);
    #1 reset_n = 1'h1;
    check(sink_on, 8'h00);
    check({6'h00, cascade_out, load_ready}, 8'h01);
    // Corner words first, then random ones
    for (i = 0; i < 8; i++) begin
      last = (i == 0) ? 8'hFF : (i == 1) ? 8'hA5 : 8'($random(seed));
      send_byte(last);
      load_word();
      check(sink_on, last);
      send_byte(~last);
      check(sink_on, last);
      host.set_pins(1'h1, 1'h1);
      @(posedge clk) #1;
      check(sink_on, 8'h00);
      host.set_pins(1'h1, 1'h0);
      @(posedge clk) #1;
      check(sink_on, last);
    end
    // Clear with ones in every stage: outputs gated, stage emptied
    send_byte(8'hFF);
    host.set_pins(1'h0, 1'h0);
    @(posedge clk) #1;
    check(sink_on, 8'h00);
    check({7'h00, cascade_out}, 8'h00);
    // A shift edge while clear is low must be refused
    host.shift_bit(1'h1);
    check({7'h00, cascade_out}, 8'h00);
    host.set_pins(1'h1, 1'h0);
    @(posedge clk) #1;
    check(sink_on, last);
    sr = 8'h00;
    load_word();
    check(sink_on, 8'h00);
    // Fill the buffer while stalled, one word past full is dropped
    storage_hold = 1'h1;
    for (i = 0; i < 33; i++) begin
      send_byte(8'($random(seed)));
      if (i == 31)
        last = sr;
      host.pulse_load();
    end
    check(sink_on, 8'h00);
    check({7'h00, load_ready}, 8'h00);
    storage_hold = 1'h0;
    repeat (40) @(posedge clk);
    #1;
    check(sink_on, last);
    check({7'h00, load_ready}, 8'h01);
    stop_test();
  end
endmodule
